/* include/dog_map.svh */
// Register offsets, field positions, reset values and frame counts of the guard block.
`ifndef DOG_MAP_SVH
`define DOG_MAP_SVH

// Register offsets on the serial configuration port.
`define DOG_ADDR_GUARD_CTRL 15'h012c
`define DOG_ADDR_THERMAL_CTRL 15'h012f
`define DOG_ADDR_THERMAL_LOW 15'h0132
`define DOG_ADDR_THERMAL_HIGH 15'h0133
`define DOG_ADDR_THERMAL_REFRESH 15'h0134
`define DOG_ADDR_BIAS_CTRL 15'h0135
`define DOG_ADDR_I_WHOLE_LOW 15'h0136
`define DOG_ADDR_I_WHOLE_HIGH 15'h0137
`define DOG_ADDR_Q_WHOLE_LOW 15'h0138
`define DOG_ADDR_Q_WHOLE_HIGH 15'h0139
`define DOG_ADDR_I_FRACTION 15'h013a
`define DOG_ADDR_Q_FRACTION 15'h013b
`define DOG_ADDR_I_GAIN_LOW 15'h013c
`define DOG_ADDR_I_GAIN_HIGH 15'h013d

// Field positions.
`define DOG_BIT_PROTECT 7
`define DOG_BIT_POWER_GUARD 0
`define DOG_BIT_SENSOR_EN 0
`define DOG_BIT_REFRESH 0
`define DOG_BIT_BIAS_EN 0
`define DOG_AUX_MSB 6
`define DOG_AUX_LSB 4
`define DOG_FRAC_MSB 4
`define DOG_GAIN_HI_MSB 3

// Reset values.
`define DOG_RST_PROTECT 1'h1
`define DOG_RST_POWER_GUARD 1'h1
`define DOG_RST_AUX_CURRENT 3'h2
`define DOG_RST_GAIN 12'h0800
`define DOG_RST_BYTE 8'h00
`define DOG_RST_CODE 16'h0000

// Serial frame: 16 command bits, then 8 data bits.
`define DOG_CMD_LAST 5'h0f
`define DOG_DATA_FIRST 5'h10
`define DOG_DATA_LAST 5'h17
`define DOG_CNT_ONE 5'h01

`endif

/* include/dog_pkg.sv */
// Types shared by the guard and offset register block.
package dog_pkg;

	// Serial port frame phases, one-hot.
	typedef enum logic [3:0] {
		DOG_IDLE = 4'b0001,
		DOG_CMD = 4'b0010,
		DOG_DATA = 4'b0100,
		DOG_DONE = 4'b1000
	} dog_phase_e;

	typedef logic signed [15:0] dog_sample_t;

endpackage

/* rtl/dog_regs.sv */
// Output guard, die temperature readback, DC offset and I gain registers with their datapath.
`timescale 1ns/1ps
`include "dog_map.svh"
module dog_regs (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic spi_sclk,
	input wire logic spi_cs_b,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	input wire logic error_event,
	input wire logic power_over,
	input wire logic output_restart,
	output logic output_off,
	output logic temp_sensor_on,
	input wire logic [15:0] temp_code_in,
	output logic [2:0] aux_converter_current,
	input wire logic [15:0] i_sample,
	input wire logic [15:0] q_sample,
	input wire logic sample_valid,
	output logic [15:0] i_out,
	output logic [15:0] q_out,
	output logic out_valid
);

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	// Bit 0 is the serial clock, bit 1 the select, bit 2 the data in.
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic [2:0] pin_s3;
	logic [2:0] pin_f;
	logic sclk_prev;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_on;

	// Three stages; a level counts only once the last two agree, which rejects one-cycle glitches.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1 <= 3'h2;
			pin_s2 <= 3'h2;
			pin_s3 <= 3'h2;
			pin_f <= 3'h2;
			sclk_prev <= 1'b0;
		end else begin
			pin_s1 <= {spi_sdi, spi_cs_b, spi_sclk};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f <= (~(pin_s2 ^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin_f);
			sclk_prev <= pin_f[0];
		end
	end

	assign sclk_rise = pin_f[0] & ~sclk_prev;
	assign sclk_fall = ~pin_f[0] & sclk_prev;
	assign cs_on = ~pin_f[1];

	// ==========================================================
	// Serial frame engine
	// ==========================================================
	dog_pkg::dog_phase_e phase;
	logic [4:0] bit_cnt;
	logic [15:0] cmd_shift;
	logic [6:0] wr_shift;
	logic [7:0] rd_shift;
	logic wr_stb;
	logic [14:0] wr_addr;
	logic [7:0] wr_byte;
	logic [7:0] rd_data;
	logic is_read;

	assign is_read = cmd_shift[15];

	// Mode 0 framing: data in is taken on the rising serial clock, one byte per select.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			phase <= dog_pkg::DOG_IDLE;
			bit_cnt <= 5'h00;
			cmd_shift <= 16'h0000;
			wr_shift <= 7'h00;
			wr_stb <= 1'b0;
			wr_addr <= 15'h0000;
			wr_byte <= `DOG_RST_BYTE;
		end else begin
			wr_stb <= 1'b0;
			if (!cs_on) begin
				phase <= dog_pkg::DOG_IDLE;
				bit_cnt <= 5'h00;
			end else begin
				case (phase)
					dog_pkg::DOG_IDLE: begin
						phase <= dog_pkg::DOG_CMD;
						bit_cnt <= 5'h00;
					end
					dog_pkg::DOG_CMD: begin
						if (sclk_rise) begin
							cmd_shift <= {cmd_shift[14:0], pin_f[2]};
							bit_cnt <= bit_cnt + `DOG_CNT_ONE;
							if (bit_cnt == `DOG_CMD_LAST) begin
								phase <= dog_pkg::DOG_DATA;
							end
						end
					end
					dog_pkg::DOG_DATA: begin
						if (sclk_rise) begin
							wr_shift <= {wr_shift[5:0], pin_f[2]};
							bit_cnt <= bit_cnt + `DOG_CNT_ONE;
							if (bit_cnt == `DOG_DATA_LAST) begin
								phase <= dog_pkg::DOG_DONE;
								wr_stb <= ~is_read;
								wr_addr <= cmd_shift[14:0];
								wr_byte <= {wr_shift, pin_f[2]};
							end
						end
					end
					dog_pkg::DOG_DONE: begin
						phase <= dog_pkg::DOG_DONE;
					end
					default: begin
						phase <= dog_pkg::DOG_IDLE;
					end
				endcase
			end
		end
	end

	// Read data leaves on falling edges; the last bit stands until the fall after the last rise.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rd_shift <= 8'h00;
			spi_sdo <= 1'b0;
			spi_sdo_oe <= 1'b0;
		end else if (!cs_on || !is_read || (sclk_fall && phase == dog_pkg::DOG_DONE)
			|| phase == dog_pkg::DOG_IDLE || phase == dog_pkg::DOG_CMD) begin
			spi_sdo_oe <= 1'b0;
			spi_sdo <= 1'b0;
		end else if (sclk_fall && phase == dog_pkg::DOG_DATA) begin
			spi_sdo_oe <= 1'b1;
			if (bit_cnt == `DOG_DATA_FIRST) begin
				rd_shift <= {rd_data[6:0], 1'b0};
				spi_sdo <= rd_data[7];
			end else begin
				rd_shift <= {rd_shift[6:0], 1'b0};
				spi_sdo <= rd_shift[7];
			end
		end
	end

	// ==========================================================
	// Register file
	// ==========================================================
	logic protect_mode;
	logic power_guard_shutdown;
	logic sensor_enable;
	logic refresh_bit;
	logic refresh_prev;
	logic bias_offset_enable;
	logic [15:0] temp_code;
	logic [15:0] i_bias_whole;
	logic [15:0] q_bias_whole;
	logic [4:0] i_bias_fraction;
	logic [4:0] q_bias_fraction;
	logic [11:0] i_path_gain;

	// Control writes; unmapped offsets are ignored and reserved bits are not stored.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			protect_mode <= `DOG_RST_PROTECT;
			power_guard_shutdown <= `DOG_RST_POWER_GUARD;
			sensor_enable <= 1'b0;
			aux_converter_current <= `DOG_RST_AUX_CURRENT;
			refresh_bit <= 1'b0;
			bias_offset_enable <= 1'b0;
			i_bias_whole <= 16'h0000;
			q_bias_whole <= 16'h0000;
			i_bias_fraction <= 5'h00;
			q_bias_fraction <= 5'h00;
			i_path_gain <= `DOG_RST_GAIN;
		end else if (wr_stb) begin
			if (wr_addr == `DOG_ADDR_GUARD_CTRL) begin
				protect_mode <= wr_byte[`DOG_BIT_PROTECT];
				power_guard_shutdown <= wr_byte[`DOG_BIT_POWER_GUARD];
			end else if (wr_addr == `DOG_ADDR_THERMAL_CTRL) begin
				sensor_enable <= wr_byte[`DOG_BIT_SENSOR_EN];
				aux_converter_current <= wr_byte[`DOG_AUX_MSB:`DOG_AUX_LSB];
			end else if (wr_addr == `DOG_ADDR_THERMAL_REFRESH) begin
				refresh_bit <= wr_byte[`DOG_BIT_REFRESH];
			end else if (wr_addr == `DOG_ADDR_BIAS_CTRL) begin
				bias_offset_enable <= wr_byte[`DOG_BIT_BIAS_EN];
			end else if (wr_addr == `DOG_ADDR_I_WHOLE_LOW) begin
				i_bias_whole[7:0] <= wr_byte;
			end else if (wr_addr == `DOG_ADDR_I_WHOLE_HIGH) begin
				i_bias_whole[15:8] <= wr_byte;
			end else if (wr_addr == `DOG_ADDR_Q_WHOLE_LOW) begin
				q_bias_whole[7:0] <= wr_byte;
			end else if (wr_addr == `DOG_ADDR_Q_WHOLE_HIGH) begin
				q_bias_whole[15:8] <= wr_byte;
			end else if (wr_addr == `DOG_ADDR_I_FRACTION) begin
				i_bias_fraction <= wr_byte[`DOG_FRAC_MSB:0];
			end else if (wr_addr == `DOG_ADDR_Q_FRACTION) begin
				q_bias_fraction <= wr_byte[`DOG_FRAC_MSB:0];
			end else if (wr_addr == `DOG_ADDR_I_GAIN_LOW) begin
				i_path_gain[7:0] <= wr_byte;
			end else if (wr_addr == `DOG_ADDR_I_GAIN_HIGH) begin
				i_path_gain[11:8] <= wr_byte[`DOG_GAIN_HI_MSB:0];
			end
		end
	end

	// Readback mux; unmapped offsets and reserved bits read as zero.
	always_comb begin
		rd_data = 8'h00;
		if (cmd_shift[14:0] == `DOG_ADDR_GUARD_CTRL) begin
			rd_data[`DOG_BIT_PROTECT] = protect_mode;
			rd_data[`DOG_BIT_POWER_GUARD] = power_guard_shutdown;
		end else if (cmd_shift[14:0] == `DOG_ADDR_THERMAL_CTRL) begin
			rd_data[`DOG_AUX_MSB:`DOG_AUX_LSB] = aux_converter_current;
			rd_data[`DOG_BIT_SENSOR_EN] = sensor_enable;
		end else if (cmd_shift[14:0] == `DOG_ADDR_THERMAL_LOW) begin
			rd_data = temp_code[7:0];
		end else if (cmd_shift[14:0] == `DOG_ADDR_THERMAL_HIGH) begin
			rd_data = temp_code[15:8];
		end else if (cmd_shift[14:0] == `DOG_ADDR_THERMAL_REFRESH) begin
			rd_data[`DOG_BIT_REFRESH] = refresh_bit;
		end else if (cmd_shift[14:0] == `DOG_ADDR_BIAS_CTRL) begin
			rd_data[`DOG_BIT_BIAS_EN] = bias_offset_enable;
		end else if (cmd_shift[14:0] == `DOG_ADDR_I_WHOLE_LOW) begin
			rd_data = i_bias_whole[7:0];
		end else if (cmd_shift[14:0] == `DOG_ADDR_I_WHOLE_HIGH) begin
			rd_data = i_bias_whole[15:8];
		end else if (cmd_shift[14:0] == `DOG_ADDR_Q_WHOLE_LOW) begin
			rd_data = q_bias_whole[7:0];
		end else if (cmd_shift[14:0] == `DOG_ADDR_Q_WHOLE_HIGH) begin
			rd_data = q_bias_whole[15:8];
		end else if (cmd_shift[14:0] == `DOG_ADDR_I_FRACTION) begin
			rd_data[`DOG_FRAC_MSB:0] = i_bias_fraction;
		end else if (cmd_shift[14:0] == `DOG_ADDR_Q_FRACTION) begin
			rd_data[`DOG_FRAC_MSB:0] = q_bias_fraction;
		end else if (cmd_shift[14:0] == `DOG_ADDR_I_GAIN_LOW) begin
			rd_data = i_path_gain[7:0];
		end else if (cmd_shift[14:0] == `DOG_ADDR_I_GAIN_HIGH) begin
			rd_data[`DOG_GAIN_HI_MSB:0] = i_path_gain[11:8];
		end
	end

	// ==========================================================
	// Temperature sensor control
	// ==========================================================
	// Only the edge of the refresh bit captures; holding it at one does nothing further.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			refresh_prev <= 1'b0;
			temp_code <= `DOG_RST_CODE;
			temp_sensor_on <= 1'b0;
		end else begin
			refresh_prev <= refresh_bit;
			temp_sensor_on <= sensor_enable;
			if (refresh_bit && !refresh_prev && sensor_enable) begin
				temp_code <= temp_code_in;
			end
		end
	end

	// ==========================================================
	// Output guard
	// ==========================================================
	logic guard_trip;

	assign guard_trip = protect_mode & (error_event | (power_guard_shutdown & power_over));

	// The shutdown holds until restarted; a trip in the restart cycle still wins.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			output_off <= 1'b0;
		end else if (guard_trip) begin
			output_off <= 1'b1;
		end else if (output_restart) begin
			output_off <= 1'b0;
		end
	end

	// ==========================================================
	// Sample datapath
	// ==========================================================
	// Saturates a value carrying four fraction bits to the signed sample range, flooring.
	function automatic dog_pkg::dog_sample_t dog_sat(input logic signed [22:0] v);
		logic signed [18:0] whole;
		whole = v[22:4];
		if (whole > 19'sh07fff) begin
			dog_sat = 16'sh7fff;
		end else if (whole < -19'sh08000) begin
			dog_sat = 16'sh8000;
		end else begin
			dog_sat = whole[15:0];
		end
	endfunction

	logic signed [28:0] i_prod;
	logic signed [21:0] i_scaled;
	logic signed [21:0] q_scaled;
	logic signed [21:0] i_bias;
	logic signed [21:0] q_bias;
	logic signed [22:0] i_sum;
	logic signed [22:0] q_sum;

	assign i_prod = 29'($signed(i_sample)) * 29'($signed({1'b0, i_path_gain}));
	assign i_scaled = i_prod[28:7];
	assign q_scaled = {{2{q_sample[15]}}, q_sample, 4'h0};

	assign i_bias = bias_offset_enable ?
		({{2{i_bias_whole[15]}}, i_bias_whole, 4'h0} + {{17{i_bias_fraction[4]}}, i_bias_fraction})
		: 22'sh00_0000;
	assign q_bias = bias_offset_enable ?
		({{2{q_bias_whole[15]}}, q_bias_whole, 4'h0} + {{17{q_bias_fraction[4]}}, q_bias_fraction})
		: 22'sh00_0000;
	assign i_sum = {i_scaled[21], i_scaled} + {i_bias[21], i_bias};
	assign q_sum = {q_scaled[21], q_scaled} + {q_bias[21], q_bias};

	// Gain first, then offset; one register stage keeps the outputs straight from flops.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			i_out <= 16'h0000;
			q_out <= 16'h0000;
			out_valid <= 1'b0;
		end else begin
			out_valid <= sample_valid;
			if (sample_valid) begin
				i_out <= dog_sat(i_sum);
				q_out <= dog_sat(q_sum);
			end
		end
	end

endmodule // dog_regs

/* tb/dog_regs_chk.sv */
// Port-level checker for the guard, thermal and offset register block.
`timescale 1ns/1ps
// ====================================================================
// Checker
module dog_regs_chk (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic spi_sclk,
	input wire logic spi_cs_b,
	input wire logic spi_sdi,
	input wire logic spi_sdo,
	input wire logic spi_sdo_oe,
	input wire logic error_event,
	input wire logic power_over,
	input wire logic output_restart,
	input wire logic output_off,
	input wire logic temp_sensor_on,
	input wire logic [15:0] temp_code_in,
	input wire logic [2:0] aux_converter_current,
	input wire logic [15:0] i_sample,
	input wire logic [15:0] q_sample,
	input wire logic sample_valid,
	input wire logic [15:0] i_out,
	input wire logic [15:0] q_out,
	input wire logic out_valid
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	// The shutdown latch only sets from a cause and only a restart releases it.
	guard_rise_a: assert property ($rose(output_off) |-> $past(error_event | power_over))
		else $error("output shut down without a cause");
	guard_hold_a: assert property (output_off && !output_restart |=> output_off)
		else $error("output shutdown released without restart");
	guard_clear_a: assert property (output_restart && !error_event && !power_over |=> !output_off)
		else $error("restart did not release output shutdown");

	// Results follow samples by exactly one cycle and move only with a result.
	valid_lag_a: assert property (out_valid == $past(sample_valid))
		else $error("result strobe not one cycle after sample strobe");
	out_hold_a: assert property ($changed(i_out) || $changed(q_out) |-> out_valid)
		else $error("result changed without result strobe");

	// Readback drive only inside a frame, and data steady while the serial clock is high.
	oe_rise_a: assert property ($rose(spi_sdo_oe) |-> !spi_cs_b && !spi_sclk)
		else $error("readback drive began outside a low serial clock phase");
	oe_idle_a: assert property (spi_cs_b [*8] |-> !spi_sdo_oe)
		else $error("readback still driven while deselected");
	sdo_hold_a: assert property (spi_sclk [*6] |-> $stable(spi_sdo))
		else $error("readback data moved while serial clock high");
endmodule // dog_regs_chk

bind dog_regs dog_regs_chk u_chk (.mclk, .rst_b, .spi_sclk, .spi_cs_b, .spi_sdi, .spi_sdo,
	.spi_sdo_oe, .error_event, .power_over, .output_restart, .output_off, .temp_sensor_on,
	.temp_code_in, .aux_converter_current, .i_sample, .q_sample, .sample_valid, .i_out,
	.q_out, .out_valid);

/* tb/dog_regs_bench.sv */
// Self-checking bench for the guard, thermal and offset register block.
`timescale 1ns/1ps
// ====================================================================
// Bench
module dog_regs_bench;
	logic mclk = 0, rst_b = 0, spi_sclk = 0, spi_cs_b = 1, spi_sdi = 0;
	logic error_event = 0, power_over = 0, output_restart = 0, sample_valid = 0;
	logic [15:0] temp_code_in = 16'ha5c3, i_sample = 0, q_sample = 0;
	logic spi_sdo, spi_sdo_oe, output_off, temp_sensor_on, out_valid;
	logic [2:0] aux_converter_current;
	logic [15:0] i_out, q_out;
	logic [7:0] rv;
	int fail_count = 0, num_checks = 0;
	logic [14:0] ra [14] = '{15'h012c, 15'h012f, 15'h0132, 15'h0133, 15'h0134, 15'h0135,
		15'h0136, 15'h0137, 15'h0138, 15'h0139, 15'h013a, 15'h013b, 15'h013c, 15'h013d};
	logic [7:0] rr [14] = '{8'h81, 8'h20, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 8'h08};
	logic [7:0] wv [14] = '{8'hff, 8'ha1, 8'hff, 8'hff, 8'hfe, 8'hff, 8'h5a, 8'ha5, 8'h3c,
		8'hc3, 8'hff, 8'he0, 8'hff, 8'hff};
	logic [7:0] we [14] = '{8'h81, 8'h21, 0, 0, 0, 8'h01, 8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'h1f,
		0, 8'hff, 8'h0f};
	logic [11:0] cg [6] = '{12'h800, 12'h800, 12'hfff, 12'h000, 12'h800, 12'h400};
	logic [15:0] cw [6] = '{16'h0000, 16'h0100, 16'h7fff, 16'h8000, 16'h0005, 16'hfffd};
	logic [4:0] cf [6] = '{5'h00, 5'h10, 5'h00, 5'h1f, 5'h08, 5'h00};
	logic ce [6] = '{0, 1, 1, 1, 1, 0};
	logic [15:0] cs [6] = '{16'h1234, 16'h0064, 16'h7000, 16'hfffb, 16'h0003, 16'h0007};
	logic [7:0] gc [5] = '{8'h81, 8'h81, 8'h80, 8'h01, 8'h80};
	logic [2:0] gv [5] = '{3'b101, 3'b011, 3'b010, 3'b100, 3'b101};

	// Half-period toggle gives 25 MHz.
	always #20 mclk = ~mclk;

	dog_regs uut (.mclk, .rst_b, .spi_sclk, .spi_cs_b, .spi_sdi, .spi_sdo, .spi_sdo_oe,
		.error_event, .power_over, .output_restart, .output_off, .temp_sensor_on,
		.temp_code_in, .aux_converter_current, .i_sample, .q_sample, .sample_valid,
		.i_out, .q_out, .out_valid);

	// Inputs always move 1 ns after the edge so no race with the design's sampling.
	task wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task stop_test;
		if (fail_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task rst;
		rst_b = 0;
		wt(12);
		rst_b = 1;
		wt(4);
	endtask

	// One select, 24 bits; 8 mclk per phase keeps clear of the pin filters.
	task xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd);
		logic [23:0] f;
		f = {rd, a, wd};
		spi_cs_b = 0;
		wt(8);
		for (int k = 23; k >= 0; k--) begin
			spi_sdi = f[k];
			wt(8);
			rv[k % 8] = spi_sdo;
			spi_sclk = 1;
			wt(8);
			spi_sclk = 0;
		end
		wt(8);
		spi_cs_b = 1;
		wt(10);
	endtask

	task rd(input logic [14:0] a, input logic [7:0] e);
		xfer(1, a, 8'h00);
		chk($sformatf("reg %h", a), {8'h00, rv}, {8'h00, e});
	endtask

	// Reference: gain in 1/2048 steps, offset in 1/16 LSB, floor then saturate.
	function automatic logic [15:0] mdl(input logic [15:0] s, input logic [11:0] g,
		input logic [15:0] w, input logic [4:0] f, input logic e);
		longint t;
		t = (longint'($signed(s)) * longint'(g)) >>> 7;
		if (e) begin
			t = t + longint'($signed(w)) * 16 + longint'($signed(f));
		end
		t = t >>> 4;
		if (t > 32767) t = 32767;
		if (t < -32768) t = -32768;
		return t[15:0];
	endfunction

	// Hang guard, sized at about twice the expected run.
	initial begin
		repeat (90000) @(posedge mclk);
		fail_count++;
		stop_test;
	end

	initial begin
		rst;
		// Reset values, then masking of reserved and read-only bits.
		for (int i = 0; i < 14; i++) rd(ra[i], rr[i]);
		rd(15'h0140, 8'h00);
		chk("aux", 16'(aux_converter_current), 16'h0002);
		for (int i = 0; i < 14; i++) xfer(0, ra[i], wv[i]);
		for (int i = 0; i < 14; i++) rd(ra[i], we[i]);
		rst;
		// Shutdown causes under each guard setting except protect and power guard both off, restart after each.
		for (int i = 0; i < 5; i++) begin
			xfer(0, 15'h012c, gc[i]);
			error_event = gv[i][2];
			power_over = gv[i][1];
			wt(1);
			chk("output_off", 16'(output_off), 16'(gv[i][0]));
			error_event = 0;
			power_over = 0;
			output_restart = 1;
			wt(1);
			output_restart = 0;
			chk("output_off", 16'(output_off), 16'h0000);
		end
		error_event = 1;
		output_restart = 1;
		wt(1);
		chk("output_off", 16'(output_off), 16'h0001);
		error_event = 0;
		output_restart = 0;
		// Temperature capture: disabled sensor, rising edge, steady level.
		xfer(0, 15'h0134, 8'h01);
		rd(15'h0132, 8'h00);
		xfer(0, 15'h0134, 8'h00);
		xfer(0, 15'h012f, 8'h21);
		chk("sensor_on", 16'(temp_sensor_on), 16'h0001);
		xfer(0, 15'h0134, 8'h01);
		rd(15'h0132, 8'hc3);
		rd(15'h0133, 8'ha5);
		temp_code_in = 16'h1234;
		xfer(0, 15'h0134, 8'h01);
		rd(15'h0132, 8'hc3);
		xfer(0, 15'h0134, 8'h00);
		xfer(0, 15'h0134, 8'h01);
		rd(15'h0133, 8'h12);
		// Datapath cases, two samples back to back each.
		for (int i = 0; i < 6; i++) begin
			xfer(0, 15'h013c, cg[i][7:0]);
			xfer(0, 15'h013d, {4'h0, cg[i][11:8]});
			for (int j = 0; j < 4; j++) xfer(0, 15'h0136 + 15'(j), j[0] ? cw[i][15:8] : cw[i][7:0]);
			xfer(0, 15'h013a, {3'h0, cf[i]});
			xfer(0, 15'h013b, {3'h0, cf[i]});
			xfer(0, 15'h0135, {7'h00, ce[i]});
			for (int j = 0; j < 2; j++) begin
				i_sample = j ? ~cs[i] : cs[i];
				q_sample = i_sample;
				sample_valid = 1;
				wt(1);
				chk("i_out", i_out, mdl(i_sample, cg[i], cw[i], cf[i], ce[i]));
				chk("q_out", q_out, mdl(q_sample, 12'h800, cw[i], cf[i], ce[i]));
				chk("out_valid", 16'(out_valid), 16'h0001);
			end
			sample_valid = 0;
			wt(1);
			chk("out_valid", 16'(out_valid), 16'h0000);
		end
		stop_test;
	end
endmodule // dog_regs_bench
